// File: hdl/sram_pkg.sv
package sram_pkg;

   // ***********************************
   // Organisations
   // ***********************************
   localparam int DATA_W_X18 = 18;
   localparam int ADDR_W_X18 = 20;
   localparam int DATA_W_X36 = 36;
   localparam int ADDR_W_X36 = 19;

   // ***********************************
   // Reset values and positions
   // ***********************************
   localparam int       CTL_W         = 8;
   localparam int       POS_K         = 7;
   localparam int       POS_K_N       = 6;
   localparam int       POS_C         = 5;
   localparam int       POS_C_N       = 4;
   localparam int       POS_RPS_N     = 3;
   localparam int       POS_WPS_N     = 2;
   localparam int       POS_PLL_OFF   = 1;
   localparam int       POS_SINGLE    = 0;
   localparam bit [7:0] CTL_RESET     = 8'h0c;
   localparam int       SYNC_STAGES   = 2;

   // ***********************************
   // Types
   // ***********************************
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ARM    = 2'b01,
      ST_SECOND = 2'b11
   } launch_e;

   typedef struct packed {
      logic in_rise;
      logic in_n_rise;
      logic out_rise;
      logic out_n_rise;
   } edges_s;

endpackage

// File: hdl/quad_rate_sram_interface.sv
`timescale 1ns/1ns
// Behaviour
// - One address bus: read address on K rise, write address on K_N rise.
// - Each access moves exactly two words, one after the other.
// - Words of 18 bits by 1M or 36 bits by 512K; address width follows depth.
// - With pll_off high the first read word leaves 1.5 cycles after address.
// - With pll_off low the first read word leaves one cycle after address.
// - Words move on rising edges of both clocks of each complementary pair.
// - Address, selects and write data are captured by the input clock pair.
// - Read words launch on the output pair, or the input pair in single mode.
// - Read and write ports run independently and concurrently.
// - A captured write completes itself with no further controller action.
// - Active-low read and write port selects enable each port separately.
// - A read returns the newest data, even from a same-cycle write.
// - A complementary pair of echo clocks is driven out.
// - Write select low at K rise starts a write; high ignores write data.
module quad_rate_sram_interface
   import sram_pkg::*;
#(
   parameter int DATA_W = DATA_W_X18,
   parameter int ADDR_W = ADDR_W_X18
) (
   // Clock and reset
   input  wire logic              REF_CLK_IN,
   input  wire logic              SRST_IN,
   // Clock pairs
   input  wire logic              K_IN,
   input  wire logic              K_N_IN,
   input  wire logic              C_IN,
   input  wire logic              C_N_IN,
   // Control pins
   input  wire logic              READ_PORT_SELECT_N_IN,
   input  wire logic              WRITE_PORT_SELECT_N_IN,
   input  wire logic              PLL_OFF_IN,
   input  wire logic              SINGLE_CLOCK_IN,
   // Address and write data
   input  wire logic [ADDR_W-1:0] ADDR_IN,
   input  wire logic [DATA_W-1:0] DATA_IN,
   // Read data and echo clocks
   output logic      [DATA_W-1:0] DATA_OUT,
   output logic                   ECHO_CLOCK_OUT,
   output logic                   ECHO_CLOCK_N_OUT
);

   // ***********************************
   // Input synchronisers
   // ***********************************
   localparam int BUS_W = CTL_W + ADDR_W + DATA_W;

   logic [BUS_W-1:0]  meta_reg;
   logic [BUS_W-1:0]  sync_reg;
   logic [3:0]        clk_prev_reg;
   logic [BUS_W-1:0]  sync_next;
   logic [CTL_W-1:0]  ctl;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;
   logic              out_clk;
   logic              out_clk_n;
   edges_s            edg;

   always_comb begin
      sync_next = {K_IN, K_N_IN, C_IN, C_N_IN,
                   READ_PORT_SELECT_N_IN, WRITE_PORT_SELECT_N_IN,
                   PLL_OFF_IN, SINGLE_CLOCK_IN, ADDR_IN, DATA_IN};
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         meta_reg     <= {CTL_RESET, {(ADDR_W + DATA_W){1'b0}}};
         sync_reg     <= {CTL_RESET, {(ADDR_W + DATA_W){1'b0}}};
         clk_prev_reg <= 4'h0;
      end else begin
         meta_reg     <= sync_next;
         sync_reg     <= meta_reg;
         clk_prev_reg <= sync_reg[BUS_W-1 -: 4];
      end
   end

   always_comb begin
      ctl       = sync_reg[BUS_W-1 -: CTL_W];
      addr_s    = sync_reg[DATA_W +: ADDR_W];
      data_s    = sync_reg[DATA_W-1:0];
      out_clk   = ctl[POS_SINGLE] ? ctl[POS_K]   : ctl[POS_C];
      out_clk_n = ctl[POS_SINGLE] ? ctl[POS_K_N] : ctl[POS_C_N];
      edg.in_rise   = ctl[POS_K]   & ~clk_prev_reg[3];
      edg.in_n_rise = ctl[POS_K_N] & ~clk_prev_reg[2];
      edg.out_rise  = out_clk &
         ~(ctl[POS_SINGLE] ? clk_prev_reg[3] : clk_prev_reg[1]);
      edg.out_n_rise = out_clk_n &
         ~(ctl[POS_SINGLE] ? clk_prev_reg[2] : clk_prev_reg[0]);
   end

   // ***********************************
   // Memory array
   // ***********************************
   // Depth from address width
   logic [DATA_W-1:0] mem_lo [0:(2**ADDR_W)-1];
   logic [DATA_W-1:0] mem_hi [0:(2**ADDR_W)-1];

   // ***********************************
   // Input capture and write commit
   // ***********************************
   logic              wr_pend_reg;
   logic              wr_pend_next;
   logic [DATA_W-1:0] wr_lo_reg;
   logic [DATA_W-1:0] wr_lo_next;
   logic              rd_pend_reg;
   logic              rd_pend_next;
   logic [ADDR_W-1:0] rd_addr_reg;
   logic [ADDR_W-1:0] rd_addr_next;
   logic              commit;
   logic [ADDR_W-1:0] wr_addr;
   logic              hit;

   always_comb begin
      wr_pend_next = wr_pend_reg;
      wr_lo_next   = wr_lo_reg;
      rd_pend_next = rd_pend_reg;
      rd_addr_next = rd_addr_reg;
      commit       = 1'b0;
      wr_addr      = addr_s;
      if (edg.in_rise) begin
         rd_pend_next = ~ctl[POS_RPS_N];
         if (!ctl[POS_RPS_N]) begin
            rd_addr_next = addr_s;
         end
         wr_pend_next = ~ctl[POS_WPS_N];
         if (!ctl[POS_WPS_N]) begin
            wr_lo_next = data_s;
         end
      end
      if (edg.in_n_rise && wr_pend_reg) begin
         commit       = 1'b1;
         wr_pend_next = 1'b0;
      end
      hit = commit && (wr_addr == rd_addr_reg);
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         wr_pend_reg <= 1'b0;
         wr_lo_reg   <= '0;
         rd_pend_reg <= 1'b0;
         rd_addr_reg <= '0;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_lo_reg   <= wr_lo_next;
         rd_pend_reg <= rd_pend_next;
         rd_addr_reg <= rd_addr_next;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (commit) begin
         mem_lo[wr_addr] <= wr_lo_reg;
         mem_hi[wr_addr] <= data_s;
      end
   end

   // ***********************************
   // Read hold and output launch
   // ***********************************
   logic              hold_v_reg;
   logic              hold_v_next;
   logic [DATA_W-1:0] hold_lo_reg;
   logic [DATA_W-1:0] hold_lo_next;
   logic [DATA_W-1:0] hold_hi_reg;
   logic [DATA_W-1:0] hold_hi_next;
   logic [DATA_W-1:0] second_reg;
   logic [DATA_W-1:0] second_next;
   logic [DATA_W-1:0] dout_reg;
   logic [DATA_W-1:0] dout_next;
   logic              sec_on_rise_reg;
   logic              sec_on_rise_next;
   launch_e           st_reg;
   launch_e           st_next;
   logic              echo_reg;
   logic              echo_n_reg;

   always_comb begin
      hold_v_next      = hold_v_reg;
      hold_lo_next     = hold_lo_reg;
      hold_hi_next     = hold_hi_reg;
      second_next      = second_reg;
      dout_next        = dout_reg;
      sec_on_rise_next = sec_on_rise_reg;
      st_next          = st_reg;
      case (st_reg)
         ST_IDLE: begin
            if (hold_v_reg && edg.out_rise) begin
               if (ctl[POS_PLL_OFF]) begin
                  st_next = ST_ARM;
               end else begin
                  dout_next        = hold_lo_reg;
                  second_next      = hold_hi_reg;
                  hold_v_next      = 1'b0;
                  sec_on_rise_next = 1'b0;
                  st_next          = ST_SECOND;
               end
            end
         end
         ST_ARM: begin
            if (edg.out_n_rise) begin
               dout_next        = hold_lo_reg;
               second_next      = hold_hi_reg;
               hold_v_next      = 1'b0;
               sec_on_rise_next = 1'b1;
               st_next          = ST_SECOND;
            end
         end
         ST_SECOND: begin
            if (sec_on_rise_reg ? edg.out_rise : edg.out_n_rise) begin
               dout_next = second_reg;
               st_next   = (sec_on_rise_reg && hold_v_reg)
                           ? ST_ARM : ST_IDLE;
            end
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
      if (edg.in_n_rise && rd_pend_reg) begin
         hold_v_next  = 1'b1;
         hold_lo_next = hit ? wr_lo_reg : mem_lo[rd_addr_reg];
         hold_hi_next = hit ? data_s    : mem_hi[rd_addr_reg];
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         hold_v_reg      <= 1'b0;
         hold_lo_reg     <= '0;
         hold_hi_reg     <= '0;
         second_reg      <= '0;
         dout_reg        <= '0;
         sec_on_rise_reg <= 1'b0;
         st_reg          <= ST_IDLE;
         echo_reg        <= 1'b0;
         echo_n_reg      <= 1'b0;
      end else begin
         hold_v_reg      <= hold_v_next;
         hold_lo_reg     <= hold_lo_next;
         hold_hi_reg     <= hold_hi_next;
         second_reg      <= second_next;
         dout_reg        <= dout_next;
         sec_on_rise_reg <= sec_on_rise_next;
         st_reg          <= st_next;
         echo_reg        <= out_clk;
         echo_n_reg      <= out_clk_n;
      end
   end

   assign DATA_OUT         = dout_reg;
   assign ECHO_CLOCK_OUT   = echo_reg;
   assign ECHO_CLOCK_N_OUT = echo_n_reg;

endmodule

// File: dv/sram_asserts.sv
`timescale 1ns/1ns
module sram_asserts
   import sram_pkg::*;
#(
   parameter int DATA_W = 18
) (
   // Clock and reset
   input wire logic              REF_CLK_IN,
   input wire logic              SRST_IN,
   // Pins watched
   input wire logic              K_IN,
   input wire logic              C_IN,
   input wire logic              C_N_IN,
   input wire logic              READ_PORT_SELECT_N_IN,
   input wire logic              SINGLE_CLOCK_IN,
   input wire logic [DATA_W-1:0] DATA_OUT,
   input wire logic              ECHO_CLOCK_OUT,
   input wire logic              ECHO_CLOCK_N_OUT
);
   logic [4:0] up_reg, up_next, idle_reg, idle_next;
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (SRST_IN);
   always_comb begin
      up_next = (up_reg == 5'h1f) ? up_reg : up_reg + 5'h1;
      idle_next = (idle_reg == 5'h1f) ? idle_reg : idle_reg + 5'h1;
      if (SRST_IN) up_next = 5'h0;
      if (SRST_IN || !READ_PORT_SELECT_N_IN) idle_next = 5'h0;
   end
   always_ff @(posedge REF_CLK_IN) begin
      up_reg <= up_next;
      idle_reg <= idle_next;
   end
   sequence s_launch; $changed(DATA_OUT); endsequence
   sequence s_hold; $stable(DATA_OUT) [*3]; endsequence
   sequence s_echo_hold; $stable(ECHO_CLOCK_OUT) [*3]; endsequence
   a_echo_pair: assert property (up_reg > 5'h8 |->
      ECHO_CLOCK_N_OUT == !ECHO_CLOCK_OUT) else $error("echo pair broken");
   a_echo_c: assert property (!SINGLE_CLOCK_IN && up_reg > 5'h8 &&
      !$past(SINGLE_CLOCK_IN, 4) |-> ECHO_CLOCK_OUT == $past(C_IN, 3))
      else $error("echo does not follow output clock");
   a_echo_k: assert property (SINGLE_CLOCK_IN && up_reg > 5'h8 &&
      $past(SINGLE_CLOCK_IN, 4) |-> ECHO_CLOCK_OUT == $past(K_IN, 3))
      else $error("echo does not follow input clock");
   a_echo_n_c: assert property (!SINGLE_CLOCK_IN && up_reg > 5'h8 &&
      !$past(SINGLE_CLOCK_IN, 4) |-> ECHO_CLOCK_N_OUT == $past(C_N_IN, 3))
      else $error("inverted echo does not follow clock");
   a_data_edge: assert property (s_launch |-> $changed(ECHO_CLOCK_OUT))
      else $error("read word launched off a clock edge");
   a_data_stands: assert property (s_launch |=> s_hold)
      else $error("read word too short");
   a_read_idle: assert property (idle_reg > 5'h1c |-> $stable(DATA_OUT))
      else $error("read data moved with no read");
   a_echo_run: assert property (up_reg > 5'h8 &&
      $changed(ECHO_CLOCK_OUT) |=> s_echo_hold)
      else $error("echo clock half period short");
endmodule

bind quad_rate_sram_interface sram_asserts #(.DATA_W(DATA_W)) chk (
   .REF_CLK_IN(REF_CLK_IN), .SRST_IN(SRST_IN), .K_IN(K_IN), .C_IN(C_IN),
   .C_N_IN(C_N_IN), .READ_PORT_SELECT_N_IN(READ_PORT_SELECT_N_IN),
   .SINGLE_CLOCK_IN(SINGLE_CLOCK_IN), .DATA_OUT(DATA_OUT),
   .ECHO_CLOCK_OUT(ECHO_CLOCK_OUT), .ECHO_CLOCK_N_OUT(ECHO_CLOCK_N_OUT));

// File: dv/sram_ctrl_model.sv
`timescale 1ns/1ns
module sram_ctrl_model
   import sram_pkg::*;
#(
   parameter int DW = 18,
   parameter int AW = 6
) (
   // Clock and commands
   input  wire logic          clk_in,
   input  wire logic          srst_in,
   input  wire logic          rd_in,
   input  wire logic          wr_in,
   input  wire logic          ign_in,
   input  wire logic          c_run_in,
   input  wire logic [AW-1:0] addr_in,
   input  wire logic [DW-1:0] w0_in,
   input  wire logic [DW-1:0] w1_in,
   // Pins toward the device
   output logic      [2:0]    ph_out,
   output logic               k_out,
   output logic               k_n_out,
   output logic               c_out,
   output logic               c_n_out,
   output logic               rps_n_out,
   output logic               wps_n_out,
   output logic      [AW-1:0] addr_out,
   output logic      [DW-1:0] data_out
);
   logic          wr_reg;
   logic [AW-1:0] wa_reg;
   logic [DW-1:0] w1_reg;
   // complementary pairs, output pair stops on request
   assign k_out = ~ph_out[2];
   assign k_n_out = ph_out[2];
   assign c_out = c_run_in & k_out;
   assign c_n_out = c_run_in & k_n_out;
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ph_out    <= 3'h0;
         rps_n_out <= 1'b1;
         wps_n_out <= 1'b1;
         addr_out  <= '0;
         data_out  <= '0;
         wr_reg    <= 1'b0;
      end else begin
         ph_out <= ph_out + 3'h1;
         // read address and selects for K rise
         if (ph_out == 3'h5) begin
            rps_n_out <= ~rd_in;
            wps_n_out <= ~wr_in | ign_in;
            addr_out <= rd_in ? addr_in : ~addr_out;
            data_out <= wr_in ? w0_in : ~data_out;
            wr_reg <= wr_in;
            wa_reg <= addr_in;
            w1_reg <= w1_in;
         end
         // write address and second word for K_N rise
         if (ph_out == 3'h1) begin
            addr_out <= wr_reg ? wa_reg : ~addr_out;
            data_out <= wr_reg ? w1_reg : ~data_out;
         end
      end
   end
endmodule

// File: dv/quad_rate_sram_interface_test.sv
`timescale 1ns/1ns
module quad_rate_sram_interface_test
   import sram_pkg::*;
;
   logic          clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, ign = 1'b0;
   logic          c_run = 1'b1, pll = 1'b1, single = 1'b0;
   logic [5:0]    a = 6'h00, addr;
   logic [17:0]   w0 = 18'h00000, w1 = 18'h00000, din, dout;
   logic [2:0]    ph;
   logic          k, k_n, c, c_n, rps_n, wps_n, echo, echo_n;
   int            n_mismatch = 0;
   int            total_checks = 0;
   sram_ctrl_model #(.DW(18), .AW(6)) ctl (.clk_in(clk), .srst_in(srst),
      .rd_in(rd), .wr_in(wr), .ign_in(ign), .c_run_in(c_run), .addr_in(a),
      .w0_in(w0), .w1_in(w1), .ph_out(ph), .k_out(k), .k_n_out(k_n),
      .c_out(c), .c_n_out(c_n), .rps_n_out(rps_n), .wps_n_out(wps_n),
      .addr_out(addr), .data_out(din));
   quad_rate_sram_interface #(.DATA_W(DATA_W_X18), .ADDR_W(6)) dut (
      .REF_CLK_IN(clk), .SRST_IN(srst), .K_IN(k), .K_N_IN(k_n), .C_IN(c),
      .C_N_IN(c_n), .READ_PORT_SELECT_N_IN(rps_n),
      .WRITE_PORT_SELECT_N_IN(wps_n), .PLL_OFF_IN(pll),
      .SINGLE_CLOCK_IN(single), .ADDR_IN(addr), .DATA_IN(din),
      .DATA_OUT(dout), .ECHO_CLOCK_OUT(echo), .ECHO_CLOCK_N_OUT(echo_n));
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string nm, input logic [17:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         $display("unexpected %s exp %h got %h", nm, exp, got);
         n_mismatch++;
      end
   endtask
   task automatic wait_ph(input logic [2:0] p);
      int n;
      n = 0;
      while (ph !== p) begin
         n++;
         if (n > 16) begin
            n_mismatch++;
            summarize();
         end
         @(posedge clk);
         #1;
      end
   endtask
   // ***********************************
   // One access cycle, then both words judged
   // ***********************************
   task automatic op(input logic r, input logic w, input logic [5:0] ad,
      input logic [17:0] d0, d1, e0, e1);
      wait_ph(3'h5);
      {rd, wr, a, w0, w1} = {r, w, ad, d0, d1};
      wait_ph(3'h0);
      {rd, wr} = 2'b00;
      repeat (pll ? 18 : 14) @(posedge clk);
      #1 check("word0", dout, e0);
      repeat (4) @(posedge clk);
      #1 check("word1", dout, e1);
   endtask
   task automatic t_rw();
      op(0, 1, 6'h01, 18'h3ffff, 18'h00001, 18'h0, 18'h0);
      op(1, 0, 6'h01, 18'h0, 18'h0, 18'h3ffff, 18'h00001);
      $display("test rw done");
   endtask
   task automatic t_pll();
      pll = 1'b0;
      op(1, 0, 6'h01, 18'h0, 18'h0, 18'h3ffff, 18'h00001);
      pll = 1'b1;
      $display("test latency done");
   endtask
   task automatic t_coh();
      op(1, 1, 6'h01, 18'h2aaaa, 18'h15555, 18'h2aaaa, 18'h15555);
      $display("test coherency done");
   endtask
   task automatic t_desel();
      ign = 1'b1;
      op(0, 1, 6'h01, 18'h0f0f0, 18'h30303, 18'h15555, 18'h15555);
      ign = 1'b0;
      op(1, 0, 6'h01, 18'h0, 18'h0, 18'h2aaaa, 18'h15555);
      $display("test deselect done");
   endtask
   task automatic t_single();
      single = 1'b1;
      repeat (8) @(posedge clk);
      #1 c_run = 1'b0;
      op(1, 1, 6'h3f, 18'h12345, 18'h2fedc, 18'h12345, 18'h2fedc);
      c_run = 1'b1;
      repeat (8) @(posedge clk);
      #1 single = 1'b0;
      $display("test single clock done");
   endtask
   initial begin
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (3) @(posedge clk);
      #1 srst = 1'b0;
      t_rw();
      t_pll();
      t_coh();
      t_desel();
      t_single();
      summarize();
   end
endmodule
